// [logic/batch_setpoint_sequencer.sv]
// Batch setpoint sequencer: steps, outputs, operator control
//
// Behaviour
// - Continuous output goes active low when met
// - Batch output active until condition met
// - Unsatisfied at first look jumps to branch
// - Branch zero means carry on
// - Time-of-day pulse lasts duration, actions deferred
// - Checkweigh under bit below lower limit
// - Checkweigh accept bit between limits
// - Checkweigh over bit above upper limit
// - Sense option inverts satisfied output value
// - Pause suspends, drops all but time-of-day/parallel/timer
// - Start while paused resumes, restores outputs
// - Reset stops and returns to first step
// - Stop halts and drops batch outputs
// - No run-permit input means always permitted
// - Stop locked in halts and holds while locked
// - Start ignored while stop locked
// - Release stop then start resumes step
// - Abort, release, start restarts from first
// - Stop and three-way switch separate inputs
// - Batch flag picks batch or continuous
// - Timer/parallel runs between start and end steps
`timescale 1ns/1ps
module batch_setpoint_sequencer
    import batch_seq_pkg::*;
#(
    parameter int N = NUM_SP,
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Scale weight and time of day (seconds since midnight)
    input wire logic [WEIGHT_W-1:0] weight_in,
    input wire logic [16:0] time_of_day_in,
    // Per-setpoint configuration
    input wire logic [N-1:0][2:0] sp_kind_in,
    input wire logic [N-1:0][WEIGHT_W-1:0] sp_target_in,
    input wire logic [N-1:0][WEIGHT_W-1:0] lower_weight_limit_in,
    input wire logic [N-1:0][WEIGHT_W-1:0] upper_weight_limit_in,
    input wire logic [N-1:0][5:0] sp_branch_in,
    input wire logic [N-1:0][5:0] sp_start_in,
    input wire logic [N-1:0][5:0] sp_end_in,
    input wire logic [N-1:0][16:0] sp_tod_in,
    input wire logic [N-1:0][16:0] sp_duration_in,
    input wire logic [N-1:0] sp_batch_in,
    input wire logic [N-1:0] sp_invert_in,
    input wire logic [IDX_W-1:0] sp_last_in,
    // Softkey pulses (same clock)
    input wire logic key_start_in,
    input wire logic key_pause_in,
    input wire logic key_reset_in,
    input wire logic key_stop_in,
    // Switch pins (asynchronous)
    input wire logic run_permit_input_in,
    input wire logic run_permit_assigned_in,
    input wire logic switch_start_in,
    input wire logic switch_abort_in,
    // Outputs
    output logic [N-1:0] setpoint_output_bit_out,
    output logic under_output_bit_out,
    output logic accept_output_bit_out,
    output logic over_output_bit_out,
    output logic [IDX_W-1:0] step_out,
    output logic [1:0] state_out,
    output logic action_pulse_out
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, separate per switch
    logic [1:0] perm_s_q, start_s_q, abort_s_q;
    logic start_prev_q;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            perm_s_q <= 2'b00;
            start_s_q <= 2'b00;
            abort_s_q <= 2'b00;
            start_prev_q <= 1'b0;
        end else begin
            perm_s_q <= {perm_s_q[0], run_permit_input_in};
            start_s_q <= {start_s_q[0], switch_start_in};
            abort_s_q <= {abort_s_q[0], switch_abort_in};
            start_prev_q <= start_s_q[1];
        end
    end

    // Permit forced on when no input is assigned
    wire permit = !run_permit_assigned_in || perm_s_q[1];
    wire sw_start = start_s_q[1] && !start_prev_q;
    wire start_req = (sw_start || key_start_in) && permit;
    wire abort_lvl = abort_s_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    seq_state_t state_q, state_d;
    logic [IDX_W-1:0] step_q, step_d;
    logic first_q, first_d;
    logic rewind_q, rewind_d;
    logic [N-1:0] par_on_q, par_on_d;
    logic [N-1:0] done_q, done_d;
    logic [N-1:0] tod_on_q;
    logic [N-1:0][16:0] tod_cnt_q;
    logic [$clog2(TICK+1)-1:0] tick_cnt_q;
    logic tod_act_q;
    logic [N-1:0] out_q;
    logic under_q, accept_q, over_q, act_q;

    function automatic logic [IDX_W-1:0] sp_index(input logic [5:0] num);
        sp_index = IDX_W'(num - 6'h01);
    endfunction

    sp_eval_if ev ();
    assign ev.weight = weight_in;
    assign ev.target = sp_target_in[step_q];
    assign ev.lower = lower_weight_limit_in[step_q];
    assign ev.upper = upper_weight_limit_in[step_q];
    sp_compare u_cmp (.ev(ev));

    wire sp_kind_t cur_kind = sp_kind_t'(sp_kind_in[step_q]);
    wire [5:0] cur_branch = sp_branch_in[step_q];
    wire is_par = cur_kind == KIND_TIMER || cur_kind == KIND_PARALLEL;
    wire cur_met = (cur_kind == KIND_TOD) ? 1'b1 :
                   (cur_kind == KIND_CHECK) ? ev.accept : ev.satisfied;
    wire running = state_q == ST_RUN;
    wire at_last = step_q >= sp_last_in;
    wire [IDX_W-1:0] next_step = at_last ? FIRST_STEP : step_q + 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Next-state decision
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        first_d = first_q;
        rewind_d = rewind_q || abort_lvl;
        par_on_d = par_on_q;
        done_d = done_q;
        if (key_reset_in) begin
            state_d = ST_IDLE;
            step_d = FIRST_STEP;
            first_d = 1'b1;
            par_on_d = '0;
            done_d = '0;
            rewind_d = 1'b0;
        end else if (key_stop_in && state_q != ST_IDLE) begin
            state_d = ST_HALT;
        end else if (running && !permit) begin
            state_d = ST_HALT;
        end else if (key_pause_in && running) begin
            state_d = ST_PAUSE;
        end else if (start_req && state_q != ST_RUN) begin
            state_d = ST_RUN;
            if (rewind_q || abort_lvl || state_q == ST_IDLE) begin
                step_d = FIRST_STEP;
                first_d = 1'b1;
                par_on_d = '0;
                done_d = '0;
            end
            rewind_d = 1'b0;
        end else if (running) begin
            // Parallel setpoints: start/end tied to beginning of steps
            if (first_q) begin
                for (int i = 0; i < N; i++) begin
                    if (sp_start_in[i] != NO_BRANCH &&
                        sp_index(sp_start_in[i]) == step_q)
                        par_on_d[i] = 1'b1;
                    if (sp_end_in[i] != NO_BRANCH &&
                        sp_index(sp_end_in[i]) == step_q)
                        par_on_d[i] = 1'b0;
                end
            end
            first_d = 1'b0;
            if (is_par) begin
                step_d = next_step;
                first_d = 1'b1;
            end else if (first_q && !cur_met && cur_branch != NO_BRANCH) begin
                step_d = sp_index(cur_branch);
                first_d = 1'b1;
            end else if (cur_met && !(cur_kind == KIND_TOD &&
                                      tod_on_q[step_q])) begin
                // Unsatisfied with branch zero simply waits here
                done_d[step_q] = 1'b1;
                step_d = next_step;
                first_d = 1'b1;
                if (at_last)
                    done_d = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output value per setpoint; low is active
    logic [N-1:0] drive;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            logic act;
            logic off;
            act = 1'b0;
            // Halt parks all but time-of-day pins idle, pause also spares timer/parallel, inverted or not
            off = (state_q == ST_HALT && sp_kind_in[i] != KIND_TOD) ||
                  (state_q == ST_PAUSE && sp_kind_in[i] != KIND_TOD &&
                   sp_kind_in[i] != KIND_TIMER &&
                   sp_kind_in[i] != KIND_PARALLEL);
            if (sp_kind_in[i] == KIND_TOD)
                act = tod_on_q[i];
            else if (sp_kind_in[i] == KIND_TIMER ||
                     sp_kind_in[i] == KIND_PARALLEL)
                act = par_on_q[i] && state_q != ST_HALT &&
                      state_q != ST_IDLE;
            else if (sp_batch_in[i])
                act = running && step_q == IDX_W'(i) &&
                      !cur_met;
            else
                act = done_q[i] && state_q != ST_HALT;
            drive[i] = (!off && (act ^ sp_invert_in[i])) ? OUT_ACTIVE :
                       OUT_IDLE;
        end
    end

    wire chk_live = running && cur_kind == KIND_CHECK;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            step_q <= FIRST_STEP;
            first_q <= 1'b1;
            rewind_q <= 1'b0;
            par_on_q <= '0;
            done_q <= '0;
            out_q <= '1;
            under_q <= OUT_IDLE;
            accept_q <= OUT_IDLE;
            over_q <= OUT_IDLE;
            act_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            first_q <= first_d;
            rewind_q <= rewind_d;
            par_on_q <= par_on_d;
            done_q <= done_d;
            out_q <= drive;
            under_q <= (chk_live && ev.under) ? OUT_ACTIVE : OUT_IDLE;
            accept_q <= (chk_live && ev.accept) ? OUT_ACTIVE : OUT_IDLE;
            over_q <= (chk_live && ev.over) ? OUT_ACTIVE : OUT_IDLE;
            act_q <= tod_act_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-of-day pulses: one-second tick, countdown per setpoint
    wire tick = tick_cnt_q == TICK - 1;
    logic tod_end;
    always_comb begin
        tod_end = 1'b0;
        for (int i = 0; i < N; i++)
            if (tod_on_q[i] && tick && tod_cnt_q[i] <= 17'h00001)
                tod_end = 1'b1;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_q <= '0;
            tod_on_q <= '0;
            tod_cnt_q <= '0;
            tod_act_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
            tod_act_q <= tod_end;
            for (int i = 0; i < N; i++) begin
                if (sp_kind_in[i] == KIND_TOD && !tod_on_q[i] && tick &&
                    time_of_day_in == sp_tod_in[i] &&
                    sp_duration_in[i] != 17'h00000) begin
                    tod_on_q[i] <= 1'b1;
                    tod_cnt_q[i] <= sp_duration_in[i];
                end else if (tod_on_q[i] && tick) begin
                    tod_cnt_q[i] <= tod_cnt_q[i] - 17'h00001;
                    if (tod_cnt_q[i] <= 17'h00001)
                        tod_on_q[i] <= 1'b0;
                end
            end
        end
    end

    assign setpoint_output_bit_out = out_q;
    assign under_output_bit_out = under_q;
    assign accept_output_bit_out = accept_q;
    assign over_output_bit_out = over_q;
    assign step_out = step_q;
    assign state_out = state_q;
    assign action_pulse_out = act_q;
endmodule // batch_setpoint_sequencer

// [logic/batch_seq_pkg.sv]
// Shared constants and types for the batch setpoint sequencer
package batch_seq_pkg;
    localparam int NUM_SP = 32;
    localparam int IDX_W = 5;
    localparam int WEIGHT_W = 24;
    localparam logic [WEIGHT_W-1:0] LIMIT_MAX = 24'h98967F;
    localparam logic [IDX_W-1:0] FIRST_STEP = 5'h00;
    localparam logic [5:0] NO_BRANCH = 6'h00;
    localparam int CLK_HZ = 200_000_000;
    localparam int SEC_NS = 1_000_000_000;
    localparam int CLK_PERIOD_NS = SEC_NS / CLK_HZ;
    localparam int TICK_TIME_S = 1;
    localparam int TICK_CYCLES = TICK_TIME_S * CLK_HZ;
    localparam logic OUT_ACTIVE = 1'b0;
    localparam logic OUT_IDLE = 1'b1;

    // Setpoint kinds
    typedef enum logic [2:0] {
        KIND_WEIGHT = 3'b000,
        KIND_TOD = 3'b001,
        KIND_CHECK = 3'b010,
        KIND_TIMER = 3'b011,
        KIND_PARALLEL = 3'b100
    } sp_kind_t;

    // Batch sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PAUSE = 2'b10,
        ST_HALT = 2'b11
    } seq_state_t;
endpackage

// [logic/sp_eval_if.sv]
// Interface carrying current-step evaluation between sequencer and evaluator
`timescale 1ns/1ps
interface sp_eval_if;
    import batch_seq_pkg::*;
    logic [WEIGHT_W-1:0] weight;
    logic [WEIGHT_W-1:0] target;
    logic [WEIGHT_W-1:0] lower;
    logic [WEIGHT_W-1:0] upper;
    logic satisfied;
    logic under;
    logic accept;
    logic over;
    modport seq (output weight, target, lower, upper,
                 input satisfied, under, accept, over);
    modport eval (input weight, target, lower, upper,
                  output satisfied, under, accept, over);
endinterface

// [logic/sp_compare.sv]
// Weight comparator for the current setpoint and checkweigh window
`timescale 1ns/1ps
module sp_compare
    import batch_seq_pkg::*;
(
    sp_eval_if.eval ev
);
    // Limits beyond the documented range are clipped
    wire [WEIGHT_W-1:0] lo_c = (ev.lower > LIMIT_MAX) ? LIMIT_MAX : ev.lower;
    wire [WEIGHT_W-1:0] hi_c = (ev.upper > LIMIT_MAX) ? LIMIT_MAX : ev.upper;
    assign ev.satisfied = ev.weight >= ev.target;
    assign ev.under = ev.weight < lo_c;
    assign ev.over = ev.weight > hi_c;
    assign ev.accept = !(ev.weight < lo_c) && !(ev.weight > hi_c);
endmodule // sp_compare

// [tb/batch_setpoint_sequencer_chk.sv]
// Port-level assertion checker for the batch setpoint sequencer
`timescale 1ns/1ps
module batch_setpoint_sequencer_chk
    import batch_seq_pkg::*;
#(
    parameter int N = NUM_SP
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Configuration and commands
    input wire logic [N-1:0][2:0] sp_kind_in,
    input wire logic key_start_in,
    input wire logic key_pause_in,
    input wire logic key_reset_in,
    input wire logic key_stop_in,
    input wire logic run_permit_input_in,
    input wire logic run_permit_assigned_in,
    // Observed outputs
    input wire logic [N-1:0] setpoint_output_bit_out,
    input wire logic under_output_bit_out,
    input wire logic accept_output_bit_out,
    input wire logic over_output_bit_out,
    input wire logic [IDX_W-1:0] step_out,
    input wire logic [1:0] state_out
);
    // Bits allowed to stay driven; time-of-day outputs run free
    logic [N-1:0] keep_pause;
    logic [N-1:0] keep_halt;
    for (genvar i = 0; i < N; i++) begin : g_mask
        assign keep_halt[i] = sp_kind_in[i] == KIND_TOD;
        assign keep_pause[i] = keep_halt[i] || sp_kind_in[i] == KIND_TIMER
            || sp_kind_in[i] == KIND_PARALLEL;
    end
    ////////////////////////////////////////////////////////////////
    // One clock domain, so one default clock and disable
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Stop held in long enough to pass the pin synchroniser
    sequence s_locked;
        (run_permit_assigned_in && !run_permit_input_in) [*6];
    endsequence
    // No stronger command and no permit input in play
    sequence s_free;
        !key_reset_in && !key_stop_in && !run_permit_assigned_in;
    endsequence
    a_stop_halts: assert property (
        key_stop_in && !key_reset_in && state_out != 2'h0 |=> state_out == 2'h3)
        else $error("stop key did not halt");
    a_reset_first: assert property (key_reset_in |=>
        state_out == 2'h0 && step_out == FIRST_STEP) else $error("bad reset");
    a_halt_drops: assert property (
        state_out == 2'h3 && $past(state_out) == 2'h3
        |-> &(setpoint_output_bit_out | keep_halt)) else $error("halt output");
    a_pause_drops: assert property (
        state_out == 2'h2 && $past(state_out) == 2'h2
        |-> &(setpoint_output_bit_out | keep_pause)) else $error("pause output");
    a_pause_takes: assert property (
        key_pause_in && state_out == 2'h1 ##0 s_free |=> state_out == 2'h2)
        else $error("pause not taken");
    a_locked_stops: assert property (s_locked |-> state_out != 2'h1)
        else $error("ran while stop locked");
    a_free_start: assert property (
        key_start_in && state_out == 2'h0 ##0 s_free |=> state_out == 2'h1)
        else $error("start refused without permit input");
    a_resume_step: assert property (
        key_start_in && state_out == 2'h2 ##0 s_free
        |=> state_out == 2'h1 && $stable(step_out)) else $error("bad resume");
    a_check_onehot: assert property ($onehot0({!under_output_bit_out,
        !accept_output_bit_out, !over_output_bit_out})) else $error("check bits");
endmodule // batch_setpoint_sequencer_chk

bind batch_setpoint_sequencer batch_setpoint_sequencer_chk #(.N(N)) chk (.*);

// [tb/operator_panel_model.sv]
// Operator panel model: locking stop button and three-way switch
`timescale 1ns/1ps
module operator_panel_model (
    // Paces the operator only
    input wire logic clock_in,
    // Switch pins, each on its own input
    output logic permit_out,
    output logic start_out,
    output logic abort_out
);
    // Stop button starts locked in, switch at rest
    initial begin
        permit_out = 1'b0;
        start_out = 1'b0;
        abort_out = 1'b0;
    end
    // Lock or release the stop button, then let it settle
    task automatic lock(input logic locked);
        permit_out = !locked;
        repeat (8) @(negedge clock_in);
    endtask
    // Momentary turn to start or abort; never both at once
    task automatic flip(input logic to_abort);
        if (to_abort) abort_out = 1'b1;
        else start_out = 1'b1;
        repeat (6) @(negedge clock_in);
        start_out = 1'b0;
        abort_out = 1'b0;
        repeat (4) @(negedge clock_in);
    endtask
endmodule // operator_panel_model

// [tb/batch_setpoint_sequencer_test.sv]
// Self-checking testbench for the batch setpoint sequencer
`timescale 1ns/1ps
module batch_setpoint_sequencer_test;
    import batch_seq_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [WEIGHT_W-1:0] weight = '0;
    logic [NUM_SP-1:0][2:0] kind = '0;
    logic [NUM_SP-1:0][WEIGHT_W-1:0] target = '0;
    logic [NUM_SP-1:0][WEIGHT_W-1:0] lower = '0;
    logic [NUM_SP-1:0][WEIGHT_W-1:0] upper = '0;
    logic [NUM_SP-1:0][5:0] branch = '0;
    logic [NUM_SP-1:0] batch = '0;
    logic [NUM_SP-1:0] invert = '0;
    logic [IDX_W-1:0] last = '0;
    logic [16:0] time_of_day_setpoint = '0;
    logic [NUM_SP-1:0][5:0] sp_from = '0;
    logic [NUM_SP-1:0][5:0] sp_to = '0;
    logic [NUM_SP-1:0][16:0] tod_at = '0;
    logic [NUM_SP-1:0][16:0] tod_len = '0;
    logic pulse;
    int waited = 0;
    logic [3:0] keys = '0;
    logic assigned = 1'b0;
    logic permit, sw_start, sw_abort;
    logic [NUM_SP-1:0] bits;
    logic [2:0] uao;
    logic [IDX_W-1:0] step;
    logic [1:0] state;
    int n_fail = 0;
    int n_tests = 0;
    // Weight across the window edges, then under/accept/over
    logic [26:0] rows [6] = '{{24'h00000A, 3'h3}, {24'h000031, 3'h3},
        {24'h000032, 3'h5}, {24'h000096, 3'h5}, {24'h000097, 3'h6},
        {24'h000064, 3'h5}};
    // Short tick so seconds stay cheap in simulation
    batch_setpoint_sequencer #(.TICK(10)) uut (
        .clock_in(clock_in), .rst_in(rst_in), .weight_in(weight),
        .time_of_day_in(time_of_day_setpoint), .sp_kind_in(kind), .sp_target_in(target),
        .lower_weight_limit_in(lower), .upper_weight_limit_in(upper),
        .sp_branch_in(branch), .sp_start_in(sp_from), .sp_end_in(sp_to),
        .sp_tod_in(tod_at), .sp_duration_in(tod_len), .sp_batch_in(batch),
        .sp_invert_in(invert), .sp_last_in(last), .key_start_in(keys[0]),
        .key_pause_in(keys[1]), .key_reset_in(keys[2]), .key_stop_in(keys[3]),
        .run_permit_input_in(permit), .run_permit_assigned_in(assigned),
        .switch_start_in(sw_start), .switch_abort_in(sw_abort),
        .setpoint_output_bit_out(bits), .under_output_bit_out(uao[2]),
        .accept_output_bit_out(uao[1]), .over_output_bit_out(uao[0]),
        .step_out(step), .state_out(state), .action_pulse_out(pulse));
    operator_panel_model pan (.clock_in(clock_in), .permit_out(permit),
        .start_out(sw_start), .abort_out(sw_abort));
    ////////////////////////////////////////////////////////////////
    // Clock and a watchdog with about twenty times the expected run length
    initial forever #(CLK_PERIOD_NS / 2.0) clock_in = ~clock_in;
    initial begin
        #20000;
        n_fail++;
        finish_test();
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // One-cycle softkey: 1 start, 2 pause, 4 reset, 8 stop
    task automatic press(input logic [3:0] k, input int n);
        keys = k;
        tick(1);
        keys = 4'h0;
        tick(n);
    endtask
    task automatic check(input string what, input logic [7:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic expect2(input logic [1:0] st, input logic [4:0] sp);
        check("state", {6'h00, st}, {6'h00, state});
        check("step", {3'h0, sp}, {3'h0, step});
    endtask
    task automatic expect3(input logic [1:0] st, input logic [4:0] sp,
                           input logic [3:0] b);
        expect2(st, sp);
        check("outputs", {4'h0, b}, {4'h0, bits[3:0]});
    endtask
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Stop stays locked but no permit input is assigned at first
    initial begin
        tick(16);
        rst_in = 1'b0;
        tick(1);
        expect3(2'h0, 5'h00, 4'hF);
        kind[0] = 3'h2;
        lower[0] = 24'h000032;
        upper[0] = 24'h000096;
        press(4'h1, 3);
        foreach (rows[i]) begin
            weight = rows[i][26:3];
            tick(3);
            check("check", {5'h00, rows[i][2:0]}, {5'h00, uao});
        end
        press(4'h4, 3);
        expect2(2'h0, 5'h00);
        // Batch step, continuous step, then a batch step that never fills
        kind[0] = 3'h0;
        // Parallel setpoint 4 runs from step 1 until step 3 begins
        kind[3] = 3'h4;
        sp_from[3] = 6'h01;
        sp_to[3] = 6'h03;
        batch[2:0] = 3'h5;
        target[0] = 24'h000064;
        target[1] = 24'h00012C;
        target[2] = 24'h0003E8;
        last = 5'h02;
        weight = 24'h000000;
        press(4'h1, 3);
        expect3(2'h1, 5'h00, 4'h6);
        press(4'h2, 3);
        expect3(2'h2, 5'h00, 4'h7);
        press(4'h1, 3);
        expect3(2'h1, 5'h00, 4'h6);
        weight = 24'h000078;
        tick(4);
        expect3(2'h1, 5'h01, 4'h7);
        weight = 24'h00015E;
        tick(4);
        expect3(2'h1, 5'h02, 4'h9);
        invert[1] = 1'b1;
        tick(3);
        expect3(2'h1, 5'h02, 4'hB);
        press(4'h8, 3);
        expect3(2'h3, 5'h02, 4'hF);
        // Reinitialise after the change, then branch and the switches
        press(4'h4, 3);
        invert[1] = 1'b0;
        branch[0] = 6'h03;
        assigned = 1'b1;
        pan.lock(1'b0);
        // Empty scale so step 1 fails its first look and branches
        weight = 24'h000000;
        press(4'h1, 4);
        expect2(2'h1, 5'h02);
        // No branch now, so a restart would sit at step 1
        branch[0] = 6'h00;
        pan.lock(1'b1);
        expect2(2'h3, 5'h02);
        pan.flip(1'b0);
        expect2(2'h3, 5'h02);
        pan.lock(1'b0);
        pan.flip(1'b0);
        expect2(2'h1, 5'h02);
        pan.lock(1'b1);
        pan.flip(1'b1);
        pan.lock(1'b0);
        pan.flip(1'b0);
        expect2(2'h1, 5'h00);
        // Time-of-day pulse of two seconds; clock moves on so no retrigger
        kind[4] = 3'h1;
        tod_at[4] = 17'h00005;
        tod_len[4] = 17'h00002;
        time_of_day_setpoint = 17'h00005;
        tick(12);
        time_of_day_setpoint = 17'h00006;
        check("tod out", 8'h00, {7'h00, bits[4]});
        check("early pulse", 8'h00, {7'h00, pulse});
        while (pulse !== 1'b1 && waited < 40) begin
            tick(1);
            waited++;
        end
        check("pulse", 8'h01, {7'h00, pulse});
        check("tod end", 8'h01, {7'h00, bits[4]});
        finish_test();
    end
endmodule // batch_setpoint_sequencer_test
